// ### rtl/wake_pkg.sv
// Package of constants and types for the wakeup control and status registers
`default_nettype none
package wake_pkg;
    localparam logic [15:0] OFS_WAKE_CONTROL = 16'h5800;
    localparam logic [15:0] OFS_WAKE_FILTER_ENABLE = 16'h5808;
    localparam logic [15:0] OFS_WAKE_STATUS = 16'h5810;
    localparam int ADDR_W = 16;
    // Wake control fields
    localparam int WC_APM_EN = 0;
    localparam int WC_SIG_EN = 1;
    localparam int WC_SIG_STAT = 2;
    localparam int WC_ASSERT_APM = 3;
    // Filter enable / status fields
    localparam int F_LINK = 0;
    localparam int F_MAGIC = 1;
    localparam int F_EXACT = 2;
    localparam int F_MCAST = 3;
    localparam int F_MNG = 8;
    localparam int F_IGNORE_MGMT = 15;
    localparam int F_FLEX_LO = 16;
    localparam int F_FLEX_HI = 19;
    // Writable / readable masks
    localparam logic [31:0] WFE_MASK = 32'h000f_80ff;
    localparam logic [31:0] WS_MASK = 32'h000f_01ff;
    localparam logic [31:0] FILT_MASK = 32'h000f_00ff;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;

    typedef struct packed {
        logic [19:0] hits;
        logic mgmt_pass;
        logic mng_event;
    } match_t;

    typedef struct packed {
        logic power_on_reset_n;
        logic host_link_reset_pin_n;
        logic d3_to_d0;
        logic aux_supply_present;
        logic eeprom_load;
        logic smbus_enable;
    } pwr_evt_t;
endpackage : wake_pkg
`default_nettype wire

// ### rtl/wakeup_control_status.sv
// Wakeup control, filter enable and status registers behind an APB slave
`default_nettype none
module wakeup_control_status (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [wake_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire wake_pkg::match_t match_i,
    input wire logic match_valid_i,
    input wire wake_pkg::pwr_evt_t pwr_i,
    input wire logic apm_enable_load_i,
    input wire logic assert_apm_load_i,
    output logic wake_signal_enable_o,
    output logic wake_signal_status_o,
    output logic wake_pin_assert_o
);
    logic adv_pwr_mgmt_wake_enable_r;
    logic assert_wake_on_apm_r;
    logic wake_signal_enable_r;
    logic wake_signal_status_r;
    logic [31:0] wake_filter_enable_r;
    logic [31:0] wake_status_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    wake_pkg::pwr_evt_t pwr_q1_r;
    wake_pkg::pwr_evt_t pwr_q2_r;
    logic link_rst_prev_r;
    logic por_prev_r;
    logic wr_acc;
    logic rd_acc;
    logic sel_wc;
    logic sel_wfe;
    logic sel_ws;
    logic strb_ok;
    logic link_rise;
    logic wc_clear;
    logic por_active;
    logic por_release;
    logic [31:0] hits_en;
    logic [31:0] ws_set;
    logic [31:0] ws_clr;
    logic magic_hit;
    logic apm_wake;
    logic any_wake;
    logic [31:0] wdata_mask;

    assign wr_acc = psel_i && penable_i && pwrite_i;
    assign rd_acc = psel_i && penable_i && !pwrite_i;
    assign sel_wc = paddr_i == wake_pkg::OFS_WAKE_CONTROL;
    assign sel_wfe = paddr_i == wake_pkg::OFS_WAKE_FILTER_ENABLE;
    assign sel_ws = paddr_i == wake_pkg::OFS_WAKE_STATUS;
    // Full-word writes only; partial strobes would split shared bits
    assign strb_ok = &pstrb_i;
    assign wdata_mask = pwdata_i;

    // Power pins come from outside: two stages, no reset, so that a
    // normal reset never fakes a power-on or link release edge
    always_ff @(posedge clk_sys_i) begin
        pwr_q1_r <= pwr_i;
        pwr_q2_r <= pwr_q1_r;
        link_rst_prev_r <= pwr_q2_r.host_link_reset_pin_n;
        por_prev_r <= pwr_q2_r.power_on_reset_n;
    end
    assign por_active = !pwr_q2_r.power_on_reset_n;
    assign por_release = pwr_q2_r.power_on_reset_n && !por_prev_r;
    assign link_rise = pwr_q2_r.host_link_reset_pin_n && !link_rst_prev_r;

    assign wc_clear = !pwr_q2_r.aux_supply_present
        && (link_rise || pwr_q2_r.d3_to_d0);

    assign hits_en = {12'h000, match_i.hits} & wake_filter_enable_r
        & wake_pkg::FILT_MASK;
    assign magic_hit = match_valid_i && match_i.hits[wake_pkg::F_MAGIC]
        && adv_pwr_mgmt_wake_enable_r;

    always_comb begin
        ws_set = wake_pkg::ZERO32;
        if (match_valid_i) begin
            if (!(match_i.mgmt_pass
                    && wake_filter_enable_r[wake_pkg::F_IGNORE_MGMT])) begin
                ws_set = hits_en;
            end
            ws_set[wake_pkg::F_MNG] = match_i.mng_event;
        end
        // Magic status even without pin assertion
        if (magic_hit) begin
            ws_set[wake_pkg::F_MAGIC] = 1'b1;
        end
    end

    // APM magic wake sets wake status when assert bit set
    assign apm_wake = magic_hit && assert_wake_on_apm_r;
    assign any_wake = apm_wake
        || (match_valid_i && wake_signal_enable_r
            && |(ws_set & ~(32'h1 << wake_pkg::F_MAGIC)));

    // Remaining control bits on normal reset
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || wc_clear) begin
            adv_pwr_mgmt_wake_enable_r <= 1'b0;
            assert_wake_on_apm_r <= 1'b0;
        end else if (apm_enable_load_i || assert_apm_load_i) begin
            adv_pwr_mgmt_wake_enable_r <= apm_enable_load_i;
            assert_wake_on_apm_r <= assert_apm_load_i;
        end else if (wr_acc && sel_wc && strb_ok) begin
            adv_pwr_mgmt_wake_enable_r <= wdata_mask[wake_pkg::WC_APM_EN];
            assert_wake_on_apm_r <= wdata_mask[wake_pkg::WC_ASSERT_APM];
        end
    end

    // Shared PM bits: power-on reset or link/D3 clear, not normal reset
    always_ff @(posedge clk_sys_i) begin
        if (por_active || wc_clear) begin
            wake_signal_enable_r <= 1'b0;
            wake_signal_status_r <= 1'b0;
        end else begin
            if (wr_acc && sel_wc && strb_ok) begin
                wake_signal_enable_r <= wdata_mask[wake_pkg::WC_SIG_EN];
            end
            // Write one clears; event wins over clear
            if (any_wake) begin
                wake_signal_status_r <= 1'b1;
            end else if (wr_acc && sel_wc && strb_ok
                    && wdata_mask[wake_pkg::WC_SIG_STAT]) begin
                wake_signal_status_r <= 1'b0;
            end
        end
    end

    // Enable register layout, reserved bits forced zero
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wake_filter_enable_r <= wake_pkg::ZERO32;
            wake_filter_enable_r[wake_pkg::F_IGNORE_MGMT] <=
                pwr_q2_r.smbus_enable;
        end else begin
            if (wr_acc && sel_wfe && strb_ok) begin
                wake_filter_enable_r <= pwdata_i & wake_pkg::WFE_MASK;
            end
            if (pwr_q2_r.eeprom_load) begin
                wake_filter_enable_r[wake_pkg::F_IGNORE_MGMT] <=
                    pwr_q2_r.smbus_enable;
            end
        end
    end

    assign ws_clr = (wr_acc && sel_ws && strb_ok)
        ? (pwdata_i & wake_pkg::WS_MASK) : wake_pkg::ZERO32;

    // Ignores normal reset; cleared on power-on release
    always_ff @(posedge clk_sys_i) begin
        if (por_release) begin
            wake_status_r <= wake_pkg::ZERO32;
        end else begin
            // Later packets keep setting; set beats clear
            wake_status_r <= ((wake_status_r & ~ws_clr) | ws_set)
                & wake_pkg::WS_MASK;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            prdata_r <= wake_pkg::ZERO32;
            pslverr_r <= 1'b0;
        end else if (psel_i && !penable_i) begin
            pslverr_r <= !(sel_wc || sel_wfe || sel_ws)
                || (pwrite_i && !strb_ok);
            prdata_r <= wake_pkg::ZERO32;
            if (sel_wc) begin
                prdata_r[wake_pkg::WC_APM_EN] <= adv_pwr_mgmt_wake_enable_r;
                prdata_r[wake_pkg::WC_SIG_EN] <= wake_signal_enable_r;
                prdata_r[wake_pkg::WC_SIG_STAT] <= wake_signal_status_r;
                prdata_r[wake_pkg::WC_ASSERT_APM] <= assert_wake_on_apm_r;
            end else if (sel_wfe) begin
                prdata_r <= wake_filter_enable_r;
            end else if (sel_ws) begin
                prdata_r <= wake_status_r;
            end
        end
    end

    assign pready_o = 1'b1;
    assign prdata_o = rd_acc ? prdata_r : wake_pkg::ZERO32;
    assign pslverr_o = psel_i && penable_i && pslverr_r;
    assign wake_signal_enable_o = wake_signal_enable_r;
    assign wake_signal_status_o = wake_signal_status_r;
    // Wake pin follows status while enabled, or APM assertion
    assign wake_pin_assert_o = wake_signal_status_r
        && (wake_signal_enable_r || assert_wake_on_apm_r);
endmodule : wakeup_control_status
`default_nettype wire

// ### verification/wake_props.sv
// Port checker for the wakeup register block
`default_nettype none
module wake_props (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [wake_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic match_valid_i,
    input wire wake_pkg::pwr_evt_t pwr_i,
    input wire logic wake_signal_enable_o,
    input wire logic wake_signal_status_o,
    input wire logic wake_pin_assert_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    logic acc;
    logic wen;
    assign acc = psel_i && penable_i;
    assign wen = pwdata_i[1];
    sequence wr_ctl;
        acc && pwrite_i && pstrb_i == 4'hf
        && paddr_i == wake_pkg::OFS_WAKE_CONTROL;
    endsequence
    sequence rd_at(logic [15:0] a);
        acc && !pwrite_i && paddr_i == a;
    endsequence
    en_mirror_a: assert property (wr_ctl ##0 pwr_i.power_on_reset_n
        |=> wake_signal_enable_o == $past(wen)) else $error("wake enable");
    stat_clear_a: assert property (wr_ctl ##0 pwdata_i[2] && !match_valid_i
        |=> !wake_signal_status_o) else $error("status not cleared");
    por_clear_a: assert property (!pwr_i.power_on_reset_n
        |-> ##3 (!wake_signal_status_o && !wake_signal_enable_o))
        else $error("power-on clear");
    pin_cause_a: assert property (wake_pin_assert_o |-> wake_signal_status_o)
        else $error("pin without status");
    stat_cause_a: assert property ($rose(wake_signal_status_o)
        |-> $past(match_valid_i)) else $error("status without event");
    ws_rsvd_a: assert property (rd_at(wake_pkg::OFS_WAKE_STATUS)
        |-> (prdata_o & ~wake_pkg::WS_MASK) == 0) else $error("status rsvd");
    wfe_rsvd_a: assert property (rd_at(wake_pkg::OFS_WAKE_FILTER_ENABLE)
        |-> (prdata_o & ~wake_pkg::WFE_MASK) == 0) else $error("enable rsvd");
    unmapped_a: assert property (acc && paddr_i != 16'h5800
        && paddr_i != 16'h5808 && paddr_i != 16'h5810 |-> pslverr_o)
        else $error("unmapped accepted");
    idle_rd_a: assert property (!acc |-> prdata_o == 0) else $error("idle data");
endmodule : wake_props
bind wakeup_control_status wake_props u_props (.clk_sys_i, .rst_i,
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
    .prdata_o, .pready_o, .pslverr_o, .match_valid_i, .pwr_i,
    .wake_signal_enable_o, .wake_signal_status_o, .wake_pin_assert_o);
`default_nettype wire

// ### verification/pm_host.sv
// Power management host model driving the power event inputs
`default_nettype none
module pm_host (
    input wire logic clk_sys_i,
    output var wake_pkg::pwr_evt_t pwr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // No aux supply, so link release and D3 exit reach the control reg
    initial pwr_o = '0;
    task automatic power_on;
        pwr_o.power_on_reset_n <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        pwr_o.power_on_reset_n <= 1'b1;
        pwr_o.host_link_reset_pin_n <= 1'b1;
        @(posedge clk_sys_i);
    endtask : power_on
    task automatic d3_exit;
        pwr_o.d3_to_d0 <= 1'b1;
        @(posedge clk_sys_i);
        pwr_o.d3_to_d0 <= 1'b0;
        // Pin passes two sync stages before it clears
        repeat (3) @(posedge clk_sys_i);
    endtask : d3_exit
endmodule : pm_host
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for the wakeup register block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] WC = 16'h5800;
    localparam logic [15:0] WF = 16'h5808;
    localparam logic [15:0] WS = 16'h5810;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel = 1'b0, pen = 1'b0, pw = 1'b0, mv = 1'b0, err;
    logic [15:0] pa = 16'h0000;
    logic [31:0] pd = 32'h0000_0000, q, prdata;
    logic pready, pslverr, sig_en, sig_st, pin;
    wake_pkg::match_t m = '0;
    wake_pkg::pwr_evt_t pwr;
    int n_fail = 0, samples_checked = 0, cyc = 0;
    always #2.5 clk_sys_i = ~clk_sys_i;
    wakeup_control_status dut (.clk_sys_i, .rst_i, .psel_i(psel),
        .penable_i(pen), .pwrite_i(pw), .paddr_i(pa), .pwdata_i(pd),
        .pstrb_i(4'hf), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .match_i(m), .match_valid_i(mv),
        .pwr_i(pwr), .apm_enable_load_i(1'b0), .assert_apm_load_i(1'b0),
        .wake_signal_enable_o(sig_en), .wake_signal_status_o(sig_st),
        .wake_pin_assert_o(pin));
    pm_host pm (.clk_sys_i, .pwr_o(pwr));
    task automatic chk(input string nm, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    // Reserved enable bits always written as zero
    task automatic apb(input logic w, input logic [15:0] a,
            input logic [31:0] d);
        psel <= 1'b1;
        pw <= w;
        pa <= a;
        pd <= d;
        @(posedge clk_sys_i);
        pen <= 1'b1;
        do @(posedge clk_sys_i); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk_sys_i);
    endtask : apb
    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk($sformatf("reg %h", a), q, e);
    endtask : rd
    task automatic hit(input logic [19:0] h, input logic g, p);
        m <= '{hits: h, mgmt_pass: p, mng_event: g};
        mv <= 1'b1;
        @(posedge clk_sys_i);
        mv <= 1'b0;
        @(posedge clk_sys_i);
    endtask : hit
    task automatic t_status;
        rd(WC, 32'h0000_0000);
        rd(WF, 32'h0000_0000);
        rd(WS, 32'h0000_0000);
        apb(1'b0, 16'h5804, 32'h0000_0000);
        chk("slverr", {31'h0, err}, 32'h0000_0001);
        apb(1'b1, WF, 32'h000f_00ff);
        rd(WF, 32'h000f_00ff);
        hit(20'hf00ff, 1'b1, 1'b0);
        rd(WS, 32'h000f_01ff);
        apb(1'b1, WS, 32'h0000_0105);
        rd(WS, 32'h000f_00fa);
        apb(1'b1, WS, 32'h0000_0000);
        hit(20'h00004, 1'b0, 1'b0);
        rd(WS, 32'h000f_00fe);
        apb(1'b1, WF, 32'h0000_0008);
        apb(1'b1, WS, 32'h000f_01ff);
        hit(20'hf00ff, 1'b0, 1'b0);
        rd(WS, 32'h0000_0008);
        $display("status test done");
    endtask : t_status
    task automatic t_wake;
        apb(1'b1, WF, 32'h0000_8001);
        apb(1'b1, WC, 32'h0000_0001);
        hit(20'h00002, 1'b0, 1'b0);
        rd(WS, 32'h0000_000a);
        chk("no wake", {31'h0, sig_st}, 32'h0000_0000);
        apb(1'b1, WC, 32'h0000_0009);
        hit(20'h00002, 1'b0, 1'b0);
        chk("pin", {31'h0, pin}, 32'h0000_0001);
        rd(WC, 32'h0000_000d);
        apb(1'b1, WC, 32'h0000_0006);
        rd(WC, 32'h0000_0002);
        hit(20'h00001, 1'b0, 1'b1);
        chk("mgmt", {31'h0, sig_st}, 32'h0000_0000);
        hit(20'h00001, 1'b0, 1'b0);
        chk("link", {sig_en, sig_st}, 32'h0000_0003);
        $display("wake test done");
    endtask : t_wake
    task automatic t_resets;
        apb(1'b1, WC, 32'h0000_000b);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd(WC, 32'h0000_0006);
        rd(WS, 32'h0000_000b);
        pm.power_on();
        rd(WC, 32'h0000_0000);
        rd(WS, 32'h0000_0000);
        apb(1'b1, WC, 32'h0000_000b);
        pm.d3_exit();
        rd(WC, 32'h0000_0000);
        $display("reset test done");
    endtask : t_resets
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    // Generous ceiling: the whole run needs about 115 cycles
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            final_report();
        end
    end
    initial begin
        pm.power_on();
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        t_status();
        t_wake();
        t_resets();
        final_report();
    end
endmodule : tb
`default_nettype wire
